// ### verif/bit_clear_branch_exec_properties.sv
// Purpose: timing checks of the bit-clear and branch execute block
// Assumes: one clock domain; instruction, flag, memory and program counter ports only
// Notes:   helpers latch the word and address of each instruction taken
`include "bit_clear_branch_map.vh"
module bit_clear_branch_exec_properties (
	// Clock and reset
	input wire        aclk,
	input wire        aresetn,
	// Instruction and flags
	input wire        instr_valid,
	input wire [15:0] instr_word,
	input wire [20:0] instr_pc,
	input wire        instr_ready,
	input wire        flag_negative,
	input wire        flag_carry,
	// Data memory and program counter
	input wire [11:0] dm_addr,
	input wire        dm_rd_en,
	input wire [7:0]  dm_rdata,
	input wire        dm_wr_en,
	input wire [7:0]  dm_wdata,
	input wire        pc_load,
	input wire [20:0] pc_value
);
	reg  [15:0] w;
	reg  [20:0] p;
	wire        take = instr_valid && instr_ready;
	wire [7:0]  op   = instr_word[15:8];
	always @(posedge aclk)
	begin
		if (take)
		begin
			w <= instr_word;
			p <= instr_pc;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////
	sequence s_bc;
		take && instr_word[15:12] == `OPC_BIT_CLEAR;
	endsequence
	sequence s_br;
		take && (op == `OPC_BRANCH_NEG || op == `OPC_BRANCH_NC || op == `OPC_BRANCH_NN);
	endsequence
	property p_bc_steps;
		s_bc |=> dm_rd_en ##1 !dm_rd_en ##1 dm_wr_en;
	endproperty
	property p_bc_data;
		dm_wr_en |-> dm_wdata == ($past(dm_rdata) & ~(8'h01 << w[11:9]));
	endproperty
	property p_bc_addr;
		s_bc ##1 (!w[8] && w[7:0] > `ACCESS_INDEX_MAX) |-> dm_addr == {`ACCESS_SFR_BANK, w[7:0]};
	endproperty
	property p_neg;
		take && op == `OPC_BRANCH_NEG ##2 1'b1 |=> pc_load == $past(flag_negative);
	endproperty
	property p_nc;
		take && op == `OPC_BRANCH_NC ##2 1'b1 |=> pc_load == !$past(flag_carry);
	endproperty
	property p_nn;
		take && op == `OPC_BRANCH_NN ##2 1'b1 |=> pc_load == !$past(flag_negative);
	endproperty
	property p_target;
		pc_load |-> pc_value == p + 21'h00_0002 + {{12{w[7]}}, w[7:0], 1'b0};
	endproperty
	property p_idle;
		pc_load |=> (!instr_ready && !dm_wr_en && !pc_load) [*4] ##1 instr_ready;
	endproperty
	property p_br_nomem;
		s_br |=> !dm_rd_en ##2 !dm_wr_en;
	endproperty
	a_bc_steps: assert property (p_bc_steps) else $error("bit clear steps out of order");
	a_bc_data: assert property (p_bc_data) else $error("bit clear data wrong");
	a_bc_addr: assert property (p_bc_addr) else $error("access bank address wrong");
	a_neg: assert property (p_neg) else $error("negative branch decision wrong");
	a_nc: assert property (p_nc) else $error("carry clear branch decision wrong");
	a_nn: assert property (p_nn) else $error("not negative branch decision wrong");
	a_target: assert property (p_target) else $error("branch target wrong");
	a_idle: assert property (p_idle) else $error("idle cycle after branch broken");
	a_br_nomem: assert property (p_br_nomem) else $error("branch touched memory");
endmodule

bind bit_clear_branch_exec bit_clear_branch_exec_properties i_props (
	.aclk, .aresetn, .instr_valid, .instr_word, .instr_pc, .instr_ready,
	.flag_negative, .flag_carry, .dm_addr, .dm_rd_en, .dm_rdata, .dm_wr_en,
	.dm_wdata, .pc_load, .pc_value);

// ### verif/bit_clear_branch_exec_tb.sv
// Purpose: self-checking bench of the bit-clear and branch execute block
// Assumes: data memory is one byte that answers every read
// Notes:   off the read slot the memory byte toggles so stale data shows
`include "bit_clear_branch_map.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module bit_clear_branch_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg         instr_valid, flag_negative, flag_carry;
	reg  [7:0]  awaddr, araddr, dm_rdata, mem, op, n;
	reg  [31:0] wdata;
	reg  [15:0] instr_word;
	reg  [20:0] instr_pc, got_pc, pc, exp_t;
	reg  [11:0] index_base, got_a;
	reg  [7:0]  got_w;
	wire        awready, wready, bvalid, arready, rvalid, instr_ready;
	wire        dm_rd_en, dm_wr_en, pc_load;
	wire [1:0]  bresp, rresp, phase_slot;
	wire [31:0] rdata;
	wire [11:0] dm_addr;
	wire [7:0]  dm_wdata;
	wire [20:0] pc_value;
	integer     n_errors, samples_checked, n_load, i, tk, k0;

	bit_clear_branch_exec i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.instr_valid, .instr_word, .instr_pc, .instr_ready, .flag_negative,
		.flag_carry, .index_base, .dm_addr, .dm_rd_en, .dm_rdata, .dm_wr_en,
		.dm_wdata, .pc_load, .pc_value, .phase_slot);

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// Memory byte and load counter have this one driver, so reset lives here
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dm_rdata <= 8'h00;
			n_load <= 0;
		end
		else
		begin
			dm_rdata <= dm_rd_en ? mem : ~dm_rdata;
			if (pc_load) n_load <= n_load + 1;
		end
		if (dm_rd_en) got_a <= dm_addr;
		if (dm_wr_en) got_w <= dm_wdata;
		if (pc_load) got_pc <= pc_value;
	end
	////////////////////////////////////////
	// Waits end only by the answer or the watchdog
	task automatic axw(input [7:0] a, input [31:0] d, input [1:0] r);
		begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid);
			bready <= 1'b0;
			`CHK("bresp", r, bresp)
			// One idle edge keeps bready from being lowered and raised at once
			@(posedge aclk);
		end
	endtask
	task automatic axr(input [7:0] a, input [31:0] d, input [1:0] r);
		begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (arready) arvalid <= 1'b0;
			end while (!rvalid);
			rready <= 1'b0;
			`CHK("rdata", d, rdata)
			`CHK("rresp", r, rresp)
			@(posedge aclk);
		end
	endtask
	// Answers land within three cycles of the take, so four edges suffice
	task automatic run(input [15:0] wd, input [20:0] a);
		begin
			instr_word <= wd;
			instr_pc <= a;
			instr_valid <= 1'b1;
			do
				@(posedge aclk);
			while (!instr_ready);
			`CHK("take slot", `SLOT_DECODE, phase_slot)
			instr_valid <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask
	task automatic tally_and_finish;
		begin
			$display("mismatches %0d checks %0d", n_errors, samples_checked);
			if (n_errors == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial
	begin
		#500_000;
		n_errors++;
		tally_and_finish;
	end
	////////////////////////////////////////
	initial
	begin
		{n_errors, samples_checked} = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, instr_valid} = 0;
		{flag_negative, flag_carry, awaddr, araddr, mem} = 0;
		{wdata, instr_word, instr_pc, index_base} = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(`OFS_CONTROL, 0, `RESP_OKAY);
		axr(`OFS_LAST_TARGET, 0, `RESP_OKAY);
		axr(8'h10, 0, `RESP_SLVERR);
		axw(8'h10, 32'hffff_ffff, `RESP_SLVERR);
		axw(`OFS_BANK_SELECT, 32'h0000_0005, `RESP_OKAY);
		axr(`OFS_BANK_SELECT, 32'h0000_0005, `RESP_OKAY);
		for (i = 0; i < 8; i++)
		begin
			mem <= 8'hc7 | (8'h01 << i);
			run({4'h9, i[2:0], 1'b1, 8'h3c}, 0);
			`CHK("bc addr", 12'h53c, got_a)
			`CHK("bc data", 8'hc7 & ~(8'h01 << i), got_w)
		end
		axr(`OFS_STATUS, 32'h0000_0004, `RESP_OKAY);
		run(16'h9020, 0);
		`CHK("access addr", 12'h020, got_a)
		axw(`OFS_CONTROL, 32'h0000_0001, `RESP_OKAY);
		index_base <= 12'hffa;
		run(16'h905f, 0);
		`CHK("indexed addr", 12'h059, got_a)
		run(16'h9060, 0);
		`CHK("above index", 12'hf60, got_a)
		run(16'h9110, 0);
		`CHK("banked addr", 12'h510, got_a)
		// Mid-run reset must bring both writable registers back to zero
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(`OFS_CONTROL, 0, `RESP_OKAY);
		axr(`OFS_BANK_SELECT, 0, `RESP_OKAY);
		for (i = 0; i < 16; i++)
		begin
			flag_negative <= i[0];
			flag_carry <= i[1];
			op = i[3:2] == 0 ? 8'he6 : i[3:2] == 1 ? 8'he3 : i[3:2] == 2 ? 8'he7 : 8'he2;
			tk = i[3:2] == 0 ? i[0] : i[3:2] == 1 ? !i[1] : i[3:2] == 2 ? !i[0] : 0;
			n = i[1] ? 8'h80 : 8'h7f;
			pc = 21'h1f_fff0 - 21'(i * 4);
			exp_t = pc + 21'h00_0002 + {{12{n[7]}}, n, 1'b0};
			k0 = n_load;
			run({op, n}, pc);
			`CHK("taken", tk, n_load - k0)
			if (tk)
			begin
				`CHK("target", exp_t, got_pc)
				// Read lands inside the idle cycle, so the idle bit is still set
				axr(`OFS_STATUS, {26'h0, 1'b1, 3'(i[3:2] + 2), 1'b1, 1'b0}, `RESP_OKAY);
				axr(`OFS_LAST_TARGET, {11'h000, exp_t}, `RESP_OKAY);
			end
		end
		tally_and_finish;
	end
endmodule

// ### verilog/bit_clear_branch_exec.v
// Purpose: executes bit-clear and three flag-conditional relative branches
// Assumes: data memory answers a read in the slot after dm_rd_en
// Notes:   registers reached over AXI4-Lite; four slots per cycle
//
// What this block does
// [RL1] Bit clear zeroes one selected bit of a byte by read-modify-write.
// [RL2] Bank-access bit zero uses access bank, else bank select gives upper bits.
// [RL3] Extended set, access bank, address up to 95: indexed literal offset.
// [RL4] Opcode 1110 0110 branches only when negative flag is one.
// [RL5] Opcode 1110 0011 branches only when carry flag is zero.
// [RL6] Opcode 1110 0111 branches only when negative flag is zero.
// [RL7] Taken branch loads next instruction address plus twice signed offset.
// [RL8] Offset is two's complement, doubled, added to incremented counter.
// [RL9] Branch takes one cycle untaken, two taken; second cycle is idle.
// [RL10] Neither bit clear nor branches change any status flag.
// [RL11] Bit clear: nibble 1001, bits 11-9 position, 8 bank bit, 7-0 address.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
module bit_clear_branch_exec (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire [7:0]  awaddr,
	input  wire        awvalid,
	output wire        awready,
	// AXI4-Lite write data
	input  wire [31:0] wdata,
	input  wire [3:0]  wstrb,
	input  wire        wvalid,
	output wire        wready,
	// AXI4-Lite write response
	output reg  [1:0]  bresp,
	output reg         bvalid,
	input  wire        bready,
	// AXI4-Lite read address
	input  wire [7:0]  araddr,
	input  wire        arvalid,
	output wire        arready,
	// AXI4-Lite read data
	output reg  [31:0] rdata,
	output reg  [1:0]  rresp,
	output reg         rvalid,
	input  wire        rready,
	// Instruction fetch
	input  wire        instr_valid,
	input  wire [15:0] instr_word,
	input  wire [20:0] instr_pc,
	output wire        instr_ready,
	// Status flags and index base
	input  wire        flag_negative,
	input  wire        flag_carry,
	input  wire [11:0] index_base,
	// Data memory
	output reg  [11:0] dm_addr,
	output reg         dm_rd_en,
	input  wire [7:0]  dm_rdata,
	output reg         dm_wr_en,
	output reg  [7:0]  dm_wdata,
	// Program counter
	output reg         pc_load,
	output reg  [20:0] pc_value,
	// Phase slot
	output wire [1:0]  phase_slot
);
`include "bit_clear_branch_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Helper functions

	// Effective data address of a byte-oriented operand
	function [11:0] data_address;
		input [7:0]  f;
		input        bank_bit;
		input        ext_en;
		input [3:0]  bank;
		input [11:0] base;
		begin
			if (bank_bit)
				data_address = {bank, f}; // RL2
			else if (ext_en && (f <= `ACCESS_INDEX_MAX))
				data_address = base + {4'h0, f}; // RL3
			else if (f <= `ACCESS_INDEX_MAX)
				data_address = {4'h0, f}; // RL2
			else
				data_address = {`ACCESS_SFR_BANK, f}; // RL2
		end
	endfunction

	// Address of the following instruction plus twice the signed offset
	function [20:0] branch_target;
		input [20:0] pc;
		input [7:0]  n;
		begin
			branch_target = pc + 21'h00_0002
				+ {{12{n[7]}}, n, 1'b0}; // RL7 RL8
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////
// Slot divider and decoder

	wire       slot_start;
	wire [2:0] decoded_kind;

	phase_slot_gen slots (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.slot       (phase_slot),
		.slot_start (slot_start)
	);

	opcode_decode decoder (
		.word (instr_word),
		.kind (decoded_kind)
	);

////////////////////////////////////////////////////////////////////////////////
// Software registers

	reg        ext_enable;
	reg [3:0]  bank_select_register;
	reg [20:0] last_target;
	reg        last_taken;

	reg        aw_held;
	reg [7:0]  aw_addr_q;
	reg        w_held;
	reg [31:0] w_data_q;
	reg [3:0]  w_strb_q;

	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign arready = !rvalid;

	wire do_write = aw_held && w_held && !bvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held              <= 1'b0;
			aw_addr_q            <= 8'h00;
			w_held               <= 1'b0;
			w_data_q             <= 32'h0000_0000;
			w_strb_q             <= 4'h0;
			bvalid               <= 1'b0;
			bresp                <= `RESP_OKAY;
			ext_enable           <= `CONTROL_RESET;
			bank_select_register <= `BANK_SELECT_RESET;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= `RESP_OKAY;
				case (aw_addr_q)
					`OFS_CONTROL:
					begin
						if (w_strb_q[0])
							ext_enable <= w_data_q[`CONTROL_EXT_BIT];
					end
					`OFS_BANK_SELECT:
					begin
						if (w_strb_q[0])
							bank_select_register <= w_data_q[3:0];
					end
					// Status and target are read-only; writes are dropped
					`OFS_STATUS, `OFS_LAST_TARGET:
						bresp <= `RESP_OKAY;
					default:
						bresp <= `RESP_SLVERR;
				endcase
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Execute sequence

	reg        active;
	reg        nop_cycle;
	reg        take_pending;
	reg [2:0]  op_kind;
	reg [2:0]  last_kind;
	reg [15:0] op_word;
	reg [20:0] op_pc;

	// Fetch is held off while an instruction or its idle cycle runs
	assign instr_ready = slot_start && !active && !nop_cycle; // RL9

	wire [2:0] bit_pos   = op_word[11:9];
	wire       cond_true = (op_kind == `KIND_BRANCH_NEG) ? flag_negative : // RL4
	                       (op_kind == `KIND_BRANCH_NC)  ? !flag_carry :   // RL5
	                       (op_kind == `KIND_BRANCH_NN)  ? !flag_negative : // RL6
	                       1'b0;
	wire       is_branch = (op_kind == `KIND_BRANCH_NEG) ||
	                       (op_kind == `KIND_BRANCH_NC) ||
	                       (op_kind == `KIND_BRANCH_NN);

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			active       <= 1'b0;
			nop_cycle    <= 1'b0;
			take_pending <= 1'b0;
			op_kind      <= `KIND_NONE;
			last_kind    <= `KIND_NONE;
			op_word      <= 16'h0000;
			op_pc        <= 21'h00_0000;
			dm_addr      <= 12'h000;
			dm_rd_en     <= 1'b0;
			dm_wr_en     <= 1'b0;
			dm_wdata     <= 8'h00;
			pc_load      <= 1'b0;
			pc_value     <= 21'h00_0000;
			last_target  <= `LAST_TARGET_RESET;
			last_taken   <= 1'b0;
		end
		else
		begin
			dm_rd_en <= 1'b0;
			dm_wr_en <= 1'b0;
			pc_load  <= 1'b0;
			case (phase_slot)
				`SLOT_DECODE:
				begin
					if (instr_ready && instr_valid)
					begin
						active    <= (decoded_kind != `KIND_NONE);
						op_kind   <= decoded_kind;
						last_kind <= decoded_kind;
						op_word   <= instr_word;
						op_pc     <= instr_pc;
						if (decoded_kind == `KIND_BIT_CLEAR)
						begin
							// Read the target byte in the read slot
							dm_addr  <= data_address(instr_word[7:0], instr_word[8],
								ext_enable, bank_select_register, index_base); // RL1
							dm_rd_en <= 1'b1; // RL1
						end
					end
				end
				`SLOT_READ:
					take_pending <= 1'b0;
				`SLOT_PROCESS:
				begin
					if (active && (op_kind == `KIND_BIT_CLEAR))
					begin
						// Only the data byte is written; flags are left alone
						dm_wdata <= dm_rdata & ~(8'h01 << bit_pos); // RL1 RL10
						dm_wr_en <= 1'b1; // RL1
					end
					if (active && is_branch)
					begin
						take_pending <= cond_true;
						last_taken   <= cond_true;
						if (cond_true)
						begin
							pc_value    <= branch_target(op_pc, op_word[7:0]); // RL7
							last_target <= branch_target(op_pc, op_word[7:0]); // RL8
							pc_load     <= 1'b1; // RL7
						end
					end
				end
				`SLOT_WRITE:
				begin
					active <= 1'b0;
					// Taken branch spends the next whole cycle idle
					if (nop_cycle)
						nop_cycle <= 1'b0; // RL9
					else if (active && take_pending)
						nop_cycle <= 1'b1; // RL9
				end
				default:
					active <= 1'b0;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Register read port

	reg [31:0] read_value;
	reg [1:0]  read_resp;

	always @*
	begin
		read_value = 32'h0000_0000;
		read_resp  = `RESP_OKAY;
		case (araddr)
			`OFS_CONTROL:
				read_value[`CONTROL_EXT_BIT] = ext_enable;
			`OFS_BANK_SELECT:
				read_value[3:0] = bank_select_register;
			`OFS_STATUS:
			begin
				read_value[`STATUS_BUSY_BIT]  = active;
				read_value[`STATUS_NOP_BIT]   = nop_cycle;
				read_value[`STATUS_KIND_LSB+2:`STATUS_KIND_LSB] = last_kind;
				read_value[`STATUS_TAKEN_BIT] = last_taken;
			end
			`OFS_LAST_TARGET:
				read_value[20:0] = last_target;
			default:
				read_resp = `RESP_SLVERR;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata  <= read_value;
			rresp  <= read_resp;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end
endmodule

// ### verilog/bit_clear_branch_map.vh
// Purpose: constants of the bit-clear and flag-branch execute block
// Assumes: included by bare name, definitions only
// Notes:   register offsets are byte addresses on the AXI4-Lite bus
`ifndef BIT_CLEAR_BRANCH_MAP_VH
`define BIT_CLEAR_BRANCH_MAP_VH

// Register byte offsets
`define OFS_CONTROL        8'h00
`define OFS_BANK_SELECT    8'h04
`define OFS_STATUS         8'h08
`define OFS_LAST_TARGET    8'h0c

// Field positions
`define CONTROL_EXT_BIT    0
`define STATUS_BUSY_BIT    0
`define STATUS_NOP_BIT     1
`define STATUS_KIND_LSB    2
`define STATUS_TAKEN_BIT   5

// Reset values
`define CONTROL_RESET      1'h0
`define BANK_SELECT_RESET  4'h0
`define LAST_TARGET_RESET  21'h00_0000

// Opcode patterns
`define OPC_BIT_CLEAR      4'h9
`define OPC_BRANCH_NEG     8'he6
`define OPC_BRANCH_NC      8'he3
`define OPC_BRANCH_NN      8'he7

// Decoded instruction kinds
`define KIND_NONE          3'h0
`define KIND_BIT_CLEAR     3'h1
`define KIND_BRANCH_NEG    3'h2
`define KIND_BRANCH_NC     3'h3
`define KIND_BRANCH_NN     3'h4

// Phase slots of one instruction cycle
`define SLOT_DECODE        2'h0
`define SLOT_READ          2'h1
`define SLOT_PROCESS       2'h2
`define SLOT_WRITE         2'h3

// Addressing
`define ACCESS_INDEX_MAX   8'h5f
`define ACCESS_SFR_BANK    4'hf

// Bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### verilog/opcode_decode.v
// Purpose: classifies a 16-bit instruction word
// Assumes: word is stable while decoded
// Notes:   every other opcode reads as no kind and is ignored
module opcode_decode (
	// Instruction
	input  wire [15:0] word,
	// Decoded kind
	output reg  [2:0]  kind
);
`include "bit_clear_branch_map.vh"

	always @*
	begin
		kind = `KIND_NONE;
		if (word[15:12] == `OPC_BIT_CLEAR)
			kind = `KIND_BIT_CLEAR; // RL11
		else if (word[15:8] == `OPC_BRANCH_NEG)
			kind = `KIND_BRANCH_NEG; // RL4
		else if (word[15:8] == `OPC_BRANCH_NC)
			kind = `KIND_BRANCH_NC; // RL5
		else if (word[15:8] == `OPC_BRANCH_NN)
			kind = `KIND_BRANCH_NN; // RL6
	end
endmodule

// ### verilog/phase_slot_gen.v
// Purpose: divides the clock into four phase slots per instruction cycle
// Assumes: one slot per aclk cycle
// Notes:   slot_start pulses in the decode slot
module phase_slot_gen (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Slot outputs
	output reg  [1:0] slot,
	output wire       slot_start
);
`include "bit_clear_branch_map.vh"

	assign slot_start = (slot == `SLOT_DECODE);

	always @(posedge aclk)
	begin
		if (!aresetn)
			slot <= `SLOT_DECODE;
		else
			slot <= slot + 2'h1;
	end
endmodule
